// file: pkg/usd_pkg.sv
// constants, types and shared helpers for the serial data path
// assumes one system clock; all counts are in clock or sample ticks
package usd_pkg;
   // samples per bit and vote positions, normal / double speed
   localparam logic [4:0] SAMPLES_NORMAL   = 5'h10;
   localparam logic [4:0] SAMPLES_DOUBLE   = 5'h08;
   localparam logic [4:0] VOTE_FIRST_NORM  = 5'h08;
   localparam logic [4:0] VOTE_FIRST_DBL   = 5'h04;
   localparam logic [4:0] VOTE_MID_NORM    = 5'h09;
   localparam logic [4:0] VOTE_MID_DBL     = 5'h05;
   // character size codes
   localparam logic [2:0] CHAR_SIZE_5      = 3'h0;
   localparam logic [2:0] CHAR_SIZE_9      = 3'h7;
   localparam logic [2:0] CHAR_SIZE_RESET  = 3'h3;
   // data bits plus parity, legal range
   localparam logic [3:0] FRAME_BITS_MIN   = 4'h5;
   localparam logic [3:0] FRAME_BITS_MAX   = 4'hA;
   // receive fifo depth
   localparam logic [1:0] RX_FIFO_DEPTH    = 2'h2;
   // baud divisor reset value
   localparam logic [11:0] BAUD_DIV_RESET  = 12'h000;

   typedef enum logic [1:0] {
      RX_IDLE,
      RX_START,
      RX_BITS
   } usd_rx_state_type;

   // number of data bits for a size code (5..8, 9 for code 7)
   function automatic logic [3:0] usd_data_bits(input logic [2:0] code);
      if (code == CHAR_SIZE_9) begin
         usd_data_bits = 4'h9;
      end else if (code > 3'h3) begin
         usd_data_bits = 4'h8;
      end else begin
         usd_data_bits = 4'(code) + 4'h5;
      end
   endfunction : usd_data_bits

   // mask of valid data bits for a size code
   function automatic logic [8:0] usd_data_mask(input logic [2:0] code);
      usd_data_mask = 9'(( 10'h001 << usd_data_bits(code)) - 10'h001);
   endfunction : usd_data_mask
endpackage : usd_pkg

// file: pkg/usd_fifo_if.sv
// interface between the receiver core and its two-entry buffer
// assumes both ends run on the same clock
`timescale 1ns/1ps
`default_nettype none
interface usd_fifo_if;
   logic       push;     // store one frame
   logic [8:0] push_data; // data plus ninth bit
   logic       pop;      // discard oldest entry
   logic       flush;    // empty the buffer
   logic [8:0] head;     // oldest entry
   logic [1:0] count;    // entries held
   modport owner (output push, push_data, pop, flush,
                  input head, count);
   modport store (input push, push_data, pop, flush,
                  output head, count);
endinterface : usd_fifo_if
`default_nettype wire

// file: rtl/usd_rx_fifo.sv
// two-entry receive buffer for the serial data path
// assumes pop is only given while count is nonzero
`timescale 1ns/1ps
`default_nettype none
module usd_rx_fifo
   import usd_pkg::*;
(
   input  wire logic clock_i,   // system clock
   input  wire logic rst_n_i,   // async reset, active low
   usd_fifo_if.store f          // buffer port
);
   typedef struct packed {
      logic [1:0][8:0] mem;     // two slots
      logic [1:0]      count;   // fill level
   } usd_fifo_state_type;

   usd_fifo_state_type s_reg, s_next;

   // pop shifts slot 1 down; push lands in the first free slot
   always_comb begin
      s_next = s_reg;
      if (f.flush) begin
         s_next.count = 2'h0;
      end else begin
         if (f.pop && s_reg.count != 2'h0) begin
            s_next.mem[0] = s_reg.mem[1];
            s_next.count  = s_reg.count - 2'h1;
         end
         if (f.push && s_next.count < RX_FIFO_DEPTH) begin
            s_next.mem[s_next.count[0]] = f.push_data;
            s_next.count = s_next.count + 2'h1;
         end
      end
   end

   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign f.head  = s_reg.mem[0];
   assign f.count = s_reg.count;
endmodule : usd_rx_fifo
`default_nettype wire

// file: rtl/usd_core.sv
// serial data path: transmit buffer, shifter, receiver, address filter
// assumes the cpu side strobes are single cycle on clock_i
// Contract
// - filter drops data frames when enabled
// - filter never touches the transmitter
// - sizes 5-8: first stop bit is type
// - nine-bit size: ninth bit is type
// - type one is address, zero data
// - address frames stored and flag set
// - one size setting for both directions
// - one location: write tx, read rx
// - unused upper bits ignored, read zero
// - write while buffer full is dropped
// - buffer moves to empty shifter, shifts
// - two-entry fifo advances on each access
// - sixteen or eight samples per bit
// - first vote sample 8 or 4
// - middle vote sample 9 or 5
// - data plus parity is 5 to 10
// - double speed halves samples per bit
// - majority of three centre samples
`timescale 1ns/1ps
`default_nettype none
module usd_core
   import usd_pkg::*;
(
   input  wire logic        clock_i,             // 40 MHz clock
   input  wire logic        rst_n_i,             // async reset, low
   input  wire logic        data_wr_i,           // write data location
   input  wire logic        data_rd_i,           // read/test data loc
   input  wire logic [7:0]  data_wdata_i,        // write data
   input  wire logic        tx_ninth_bit_i,      // tx ninth bit
   input  wire logic        tx_en_i,             // transmitter enable
   input  wire logic        rx_en_i,             // receiver enable
   input  wire logic        multiproc_filter_en_i, // address filter
   input  wire logic [2:0]  char_size_sel_i,     // shared size code
   input  wire logic        stop_bit_count_sel_i, // two stop bits
   input  wire logic        double_speed_sel_i,  // 8 samples per bit
   input  wire logic [11:0] baud_divisor_i,      // clocks per sample-1
   input  wire logic        tx_complete_clr_i,   // clear tx complete
   input  wire logic        rx_line_i,           // serial input pin
   output logic             tx_line_o,           // serial output pin
   output logic [7:0]       serial_data_location_o, // rx head low
   output logic             rx_ninth_bit_o,      // rx head ninth bit
   output logic             rx_complete_flag_o,  // unread data held
   output logic             tx_complete_flag_o,  // all sent
   output logic             tx_buffer_empty_flag_o, // buffer free
   output logic             size_valid_o         // size legal
);
   typedef struct packed {
      logic             rx_sync1;   // first sync stage
      logic             rx_sync2;   // second sync stage
      logic [11:0]      baud_cnt;   // sample tick divider
      // transmitter
      logic [8:0]       tx_buf;     // transmit data buffer
      logic             tx_full;    // buffer holds data
      logic [11:0]      tx_shift;   // frame incl. start/stops
      logic [3:0]       tx_left;    // bits left to send
      logic [4:0]       tx_smp;     // sample count in bit
      logic             tx_busy;    // shifter loaded
      logic             tx_line;    // line register
      logic             tx_done;    // complete flag
      // receiver
      usd_rx_state_type rx_state;   // receive state
      logic [4:0]       rx_smp;     // sample number
      logic [3:0]       rx_idx;     // bit index
      logic [9:0]       rx_shift;   // data then stop
      logic [1:0]       votes;      // first two centre samples
      // outputs
      logic [8:0]       rd_head;    // head copy
      logic             rxc;        // receive complete
      logic             tx_empty;   // buffer free flag
      logic             size_ok;    // size legal flag
   } usd_state_type;

   usd_state_type s_reg, s_next;
   usd_fifo_if    fifo();

   logic       tick;       // one sample period elapsed
   logic [4:0] spb;        // samples per bit
   logic [4:0] v_first;    // first vote sample
   logic [4:0] v_mid;      // middle vote sample
   logic [3:0] nbits;      // data bits in frame
   logic [8:0] dmask;      // data bit mask
   logic       vote;       // majority result
   logic       ftype;      // received frame type
   logic [8:0] rx_word;    // received data, masked

   usd_rx_fifo u_fifo (
      .clock_i (clock_i),
      .rst_n_i (rst_n_i),
      .f       (fifo.store)
   );

   // speed dependent sampling constants and size dependent data width and mask
   always_comb begin
      spb     = double_speed_sel_i ? SAMPLES_DOUBLE : SAMPLES_NORMAL;
      v_first = double_speed_sel_i ? VOTE_FIRST_DBL : VOTE_FIRST_NORM;
      v_mid   = double_speed_sel_i ? VOTE_MID_DBL : VOTE_MID_NORM;
      nbits   = usd_data_bits(char_size_sel_i);
      dmask   = usd_data_mask(char_size_sel_i);
   end

   assign tick = (s_reg.baud_cnt == 12'h000);
   // two of three high gives one; the third sample is the current one,
   // so the bit is decided on the last centre sample, not one later
   assign vote = (s_reg.votes[0] & s_reg.votes[1])
               | (s_reg.votes[1] & s_reg.rx_sync2)
               | (s_reg.votes[0] & s_reg.rx_sync2);
   assign rx_word = s_reg.rx_shift[8:0] & dmask;
   // ninth data bit, or the first stop bit being decided now
   assign ftype = (char_size_sel_i == CHAR_SIZE_9)
                ? s_reg.rx_shift[8]
                : vote;

   // data location access and buffer control
   always_comb begin
      fifo.pop       = data_rd_i;
      fifo.flush     = !rx_en_i;
      fifo.push      = 1'b0;
      fifo.push_data = rx_word;
      // frame done: decision tick of the first stop bit
      if (s_reg.rx_state == RX_BITS && tick && s_reg.rx_smp == v_mid + 5'h1
          && s_reg.rx_idx == nbits) begin
         // type one is address; kept regardless of filter
         fifo.push = ftype || !multiproc_filter_en_i;
      end
   end

   // next-state logic for divider, transmitter and receiver
   always_comb begin
      s_next = s_reg;
      s_next.rx_sync1 = rx_line_i;
      s_next.rx_sync2 = s_reg.rx_sync1;
      s_next.baud_cnt = tick ? baud_divisor_i : s_reg.baud_cnt - 12'h001;

      // buffer write only while empty; filter not consulted here
      if (data_wr_i && !s_reg.tx_full) begin
         s_next.tx_buf  = {tx_ninth_bit_i, data_wdata_i} & dmask;
         s_next.tx_full = 1'b1;
      end
      if (tx_complete_clr_i) begin
         s_next.tx_done = 1'b0;
      end
      // load shifter when empty and enabled
      if (tx_en_i && s_reg.tx_full && !s_reg.tx_busy) begin
         s_next.tx_shift = 12'(({3'h7, s_reg.tx_buf} << 1)
                             & 12'({3'h7, 9'h1FF} >> 0))
                         | 12'(12'hFFF << (nbits + 4'h1));
         s_next.tx_left  = nbits + 4'h2
                         + (stop_bit_count_sel_i ? 4'h1 : 4'h0);
         s_next.tx_smp   = 5'h0;
         s_next.tx_busy  = 1'b1;
         s_next.tx_full  = 1'b0;
         s_next.tx_shift[0] = 1'b0;
      end else if (s_reg.tx_busy && tick) begin
         s_next.tx_line = s_reg.tx_shift[0];
         if (s_reg.tx_smp == spb - 5'h1) begin
            s_next.tx_smp   = 5'h0;
            s_next.tx_shift = {1'b1, s_reg.tx_shift[11:1]};
            s_next.tx_left  = s_reg.tx_left - 4'h1;
            if (s_reg.tx_left == 4'h1) begin
               s_next.tx_busy = 1'b0;
               // set wins over a same-cycle clear
               s_next.tx_done = !s_reg.tx_full;
               s_next.tx_line = 1'b1;
            end
         end else begin
            s_next.tx_smp = s_reg.tx_smp + 5'h1;
         end
      end

      // receiver state machine, one step per sample tick
      if (!rx_en_i) begin
         s_next.rx_state = RX_IDLE;
      end else if (tick) begin
         // keep the first two centre samples for the vote
         if (s_reg.rx_smp >= v_first && s_reg.rx_smp <= v_mid) begin
            s_next.votes = {s_reg.votes[0], s_reg.rx_sync2};
         end
         case (s_reg.rx_state)
            RX_IDLE: begin
               if (!s_reg.rx_sync2) begin
                  s_next.rx_state = RX_START;
                  s_next.rx_smp   = 5'h2;    // this is sample 1
               end
            end
            RX_START: begin
               s_next.rx_smp = s_reg.rx_smp + 5'h1;
               if (s_reg.rx_smp == v_mid + 5'h1) begin
                  // noise spike if vote is high
                  s_next.rx_state = vote ? RX_IDLE : RX_BITS;
                  s_next.rx_idx   = 4'h0;
               end
            end
            RX_BITS: begin
               s_next.rx_smp = (s_reg.rx_smp == spb) ? 5'h1
                             : s_reg.rx_smp + 5'h1;
               if (s_reg.rx_smp == v_mid + 5'h1) begin
                  // data bits land lsb first, then the first stop bit
                  s_next.rx_shift[s_reg.rx_idx] = vote;
                  s_next.rx_idx = s_reg.rx_idx + 4'h1;
                  // first stop bit ends the frame; early start allowed
                  if (s_reg.rx_idx == nbits) begin
                     s_next.rx_state = RX_IDLE;
                  end
               end
            end
            default: s_next.rx_state = RX_IDLE;
         endcase
      end
      if (s_reg.rx_state == RX_IDLE && !(tick && !s_reg.rx_sync2)) begin
         s_next.rx_shift = '0;
      end

      // registered view of the buffer head
      s_next.rd_head = fifo.head & dmask;
      s_next.rxc     = (fifo.count != 2'h0)
                     && !(fifo.count == 2'h1 && data_rd_i && !fifo.push);
      s_next.tx_empty = !s_next.tx_full;
      // with parity off the frame is data bits only
      s_next.size_ok = (nbits >= FRAME_BITS_MIN)
                     && (nbits <= FRAME_BITS_MAX);
   end

   // the single state register
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_reg          <= '0;
         s_reg.rx_sync1 <= 1'b1;
         s_reg.rx_sync2 <= 1'b1;
         s_reg.tx_line  <= 1'b1;
         s_reg.tx_empty <= 1'b1;
         s_reg.tx_shift <= 12'hFFF;
         s_reg.rx_state <= RX_IDLE;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tx_line_o              = s_reg.tx_line;
   assign serial_data_location_o = s_reg.rd_head[7:0];
   assign rx_ninth_bit_o         = s_reg.rd_head[8];
   assign rx_complete_flag_o     = s_reg.rxc;
   assign tx_complete_flag_o     = s_reg.tx_done;
   assign tx_buffer_empty_flag_o = s_reg.tx_empty;
   assign size_valid_o           = s_reg.size_ok;

   property p_full_write_dropped;
      @(posedge clock_i) disable iff (!rst_n_i)
      (data_wr_i && s_reg.tx_full)
      |=> s_reg.tx_buf == $past(s_reg.tx_buf);
   endproperty
   a_full_write_dropped: assert property (p_full_write_dropped)
      else $error("write accepted while buffer full");

   // decision tick of the first stop bit, the step that closes a frame
   sequence s_frame_end;
      s_reg.rx_state == RX_BITS && tick && s_reg.rx_smp == v_mid + 5'h1
      && s_reg.rx_idx == nbits;
   endsequence

   property p_filter_drops_data;
      @(posedge clock_i) disable iff (!rst_n_i)
      (s_frame_end ##0 (multiproc_filter_en_i && !ftype)) |-> !fifo.push;
   endproperty
   a_filter_drops_data: assert property (p_filter_drops_data)
      else $error("data frame stored under filter");

   property p_pop_on_read;
      @(posedge clock_i) disable iff (!rst_n_i)
      (data_rd_i && fifo.count == 2'h2 && rx_en_i && !fifo.push)
      |=> fifo.count == 2'h1;
   endproperty
   a_pop_on_read: assert property (p_pop_on_read)
      else $error("fifo did not advance on access");

   property p_rxc_clears;
      @(posedge clock_i) disable iff (!rst_n_i)
      (fifo.count == 2'h0)
      |=> ##1 (!rx_complete_flag_o || $past(fifo.push, 2));
   endproperty
   a_rxc_clears: assert property (p_rxc_clears)
      else $error("receive flag set with empty buffer");

   property p_load_shifter;
      @(posedge clock_i) disable iff (!rst_n_i)
      (tx_en_i && s_reg.tx_full && !s_reg.tx_busy)
      |=> s_reg.tx_busy && !s_reg.tx_full;
   endproperty
   a_load_shifter: assert property (p_load_shifter)
      else $error("shifter not loaded");

   property p_samples_per_bit;
      @(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |-> spb == (double_speed_sel_i ? 5'h08 : 5'h10);
   endproperty
   a_samples_per_bit: assert property (p_samples_per_bit)
      else $error("wrong samples per bit");

   property p_vote_points;
      @(posedge clock_i) disable iff (!rst_n_i)
      1'b1 |-> v_mid == v_first + 5'h1
           && v_first == (double_speed_sel_i ? 5'h04 : 5'h08);
   endproperty
   a_vote_points: assert property (p_vote_points)
      else $error("wrong vote sample numbers");

   property p_upper_zero;
      @(posedge clock_i) disable iff (!rst_n_i)
      (char_size_sel_i == CHAR_SIZE_5) |=> rx_ninth_bit_o == 1'b0
         || $past(char_size_sel_i) != CHAR_SIZE_5;
   endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("upper bits not zero");

   // address frames reach the buffer even with the filter set
   property p_address_kept;
      @(posedge clock_i) disable iff (!rst_n_i)
      (s_frame_end ##0 (ftype && rx_en_i)) |=> fifo.count != 2'h0;
   endproperty
   a_address_kept: assert property (p_address_kept)
      else $error("address frame not stored");

   // a write into a free buffer is taken whatever the filter says
   property p_write_taken;
      @(posedge clock_i) disable iff (!rst_n_i)
      (data_wr_i && !s_reg.tx_full)
      |=> s_reg.tx_full && !tx_buffer_empty_flag_o;
   endproperty
   a_write_taken: assert property (p_write_taken)
      else $error("write into free buffer lost");

   // line rests high whenever the shifter is empty
   property p_line_idle;
      @(posedge clock_i) disable iff (!rst_n_i)
      !s_reg.tx_busy |-> tx_line_o;
   endproperty
   a_line_idle: assert property (p_line_idle)
      else $error("line low with shifter empty");
endmodule : usd_core
`default_nettype wire

// file: bench/usd_node_model.sv
// behavioural serial node standing on the far side of the line
// assumes the bench hands it bit times counted in system clocks
`timescale 1ns/1ps
`default_nettype none
module usd_node_model (
   input  wire logic clock_i,  // system clock for bit timing
   input  wire logic line_i,   // device transmit line
   output logic      line_o    // device receive line
);
   // line idles high between frames, as any sender must
   initial line_o = 1'b1;

   // hold one bit level for a whole bit time
   task automatic put(input logic b, input int bt);
      line_o <= b;
      repeat (bt) @(posedge clock_i);
   endtask : put

   // start, data lsb first, optional ninth bit, two stops
   task automatic send(input logic [7:0] d, input int nb,
                       input logic nine, input logic typ, input int bt);
      put(1'b0, bt);                               // start bit
      for (int i = 0; i < nb; i++) put(d[i], bt);  // data bits
      if (nine) put(typ, bt);
      put(nine ? 1'b1 : typ, bt);
      put(1'b1, bt);
   endtask : send

   // sample nb bits at bit centres after the start edge
   task automatic recv(output logic [8:0] d, input int nb, input int bt);
      d = '0;
      @(negedge line_i);
      repeat (bt / 2) @(posedge clock_i);
      for (int i = 0; i < nb; i++) begin
         repeat (bt) @(posedge clock_i);
         d[i] = line_i;
      end
   endtask : recv
endmodule : usd_node_model
`default_nettype wire

// file: bench/test_usd_core.sv
// self-checking bench for the serial data path core
// assumes a node model on the line and strobes driven on falling edges
`timescale 1ns/1ps
`default_nettype none
module test_usd_core
   import usd_pkg::*;
;
   localparam int DIV   = 1;                         // sample every 2 clk
   localparam int BIT_N = int'(SAMPLES_NORMAL) * (DIV + 1); // normal
   localparam int BIT_D = int'(SAMPLES_DOUBLE) * (DIV + 1); // double

   logic       clock_i = 1'b0;    // system clock
   logic       rst_n_i = 1'b0;    // reset, active low
   logic       data_wr_i = 1'b0;  // write strobe
   logic       data_rd_i = 1'b0;  // read strobe
   logic [7:0] data_wdata_i = 8'h00; // write data
   logic       ninth_i = 1'b0;    // tx ninth bit
   logic       tx_en_i = 1'b1;    // transmitter on
   logic       rx_en_i = 1'b1;    // receiver on
   logic       filt_i = 1'b0;     // address filter
   logic [2:0] size_i = CHAR_SIZE_9; // shared size code
   logic       stop2_i = 1'b1;    // two stop bits
   logic       dbl_i = 1'b0;      // double speed
   logic       txc_clr_i = 1'b0;  // clear tx complete
   wire        rx_line;           // node to device
   wire        tx_line;           // device to node
   wire  [7:0] rd_data;           // fifo head low byte
   wire        rx_ninth;          // fifo head ninth bit
   wire        rxc;               // receive complete
   wire        txc;               // transmit complete
   wire        txe;               // tx buffer empty
   wire        size_ok;           // size legal
   int         error_cnt = 0;     // mismatches seen
   int         check_count = 0;   // comparisons made

   always #12.5 clock_i = ~clock_i;  // 40 MHz

   usd_core dut (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .data_wr_i(data_wr_i),
      .data_rd_i(data_rd_i), .data_wdata_i(data_wdata_i),
      .tx_ninth_bit_i(ninth_i), .tx_en_i(tx_en_i), .rx_en_i(rx_en_i),
      .multiproc_filter_en_i(filt_i), .char_size_sel_i(size_i),
      .stop_bit_count_sel_i(stop2_i), .double_speed_sel_i(dbl_i),
      .baud_divisor_i(12'(DIV)), .tx_complete_clr_i(txc_clr_i),
      .rx_line_i(rx_line), .tx_line_o(tx_line),
      .serial_data_location_o(rd_data), .rx_ninth_bit_o(rx_ninth),
      .rx_complete_flag_o(rxc), .tx_complete_flag_o(txc),
      .tx_buffer_empty_flag_o(txe), .size_valid_o(size_ok));

   usd_node_model node (.clock_i(clock_i), .line_i(tx_line),
                        .line_o(rx_line));

   // compare a nine-bit value
   task automatic check_word(input logic [8:0] got, input logic [8:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_word

   // compare a single flag
   task automatic check_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check_bit

   task automatic cyc(input int n);
      repeat (n) @(negedge clock_i);
   endtask : cyc

   // strobe held n cycles; later cycles carry b, so n=2 is back-to-back
   task automatic wr(input logic [7:0] a, input logic [7:0] b,
                     input logic n9, input int n);
      @(negedge clock_i);
      data_wdata_i = a;
      ninth_i = n9;
      data_wr_i = 1'b1;
      for (int i = 1; i < n; i++) begin
         @(negedge clock_i);
         data_wdata_i = b;
      end
      @(negedge clock_i);
      data_wr_i = 1'b0;
   endtask : wr

   // take the head, then pop it; head register needs two cycles
   task automatic rd(output logic [8:0] v);
      @(negedge clock_i);
      v = {rx_ninth, rd_data};
      data_rd_i = 1'b1;
      @(negedge clock_i);
      data_rd_i = 1'b0;
      cyc(3);
   endtask : rd

   // bounded wait for unread data, then let the head settle
   task automatic wait_rxc();
      int k;
      k = 0;
      while (rxc !== 1'b1 && k < 400) begin
         @(negedge clock_i);
         k++;
      end
      cyc(3);
   endtask : wait_rxc

   task automatic rx_frame(input logic [7:0] d, input int nb,
                           input logic nine, input logic typ, input int bt);
      node.send(d, nb, nine, typ, bt);
      cyc(4);
   endtask : rx_frame

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : give_verdict

   // watchdog: tests need roughly 4000 clocks
   initial begin
      repeat (30000) @(posedge clock_i);
      error_cnt++;
      give_verdict();
   end

   initial begin : main
      logic [8:0] v;
      logic       low_seen;
      cyc(8);
      rst_n_i = 1'b1;
      cyc(2);
      check_bit(tx_line, 1'b1);
      check_bit(txe, 1'b1);
      check_bit(rxc, 1'b0);
      for (int k = 0; k < 8; k++) begin
         size_i = 3'(k);
         cyc(1);
         check_bit(size_ok, 1'b1);
      end
      $display("test reset_and_sizes done");
      // nine-bit frames through the filter
      size_i = CHAR_SIZE_9;
      filt_i = 1'b1;
      rx_frame(8'h5A, 8, 1'b1, 1'b0, BIT_N);
      check_bit(rxc, 1'b0);
      rx_frame(8'h3C, 8, 1'b1, 1'b1, BIT_N);
      wait_rxc();
      check_bit(rxc, 1'b1);
      rd(v);
      check_word(v, 9'h13C);
      check_bit(rxc, 1'b0);
      filt_i = 1'b0;  // whole level written, flags untouched
      rx_frame(8'hC3, 8, 1'b1, 1'b0, BIT_N);
      wait_rxc();
      rd(v);
      check_word(v, 9'h0C3);
      filt_i = 1'b1;  // re-armed after the last data frame
      rx_frame(8'h77, 8, 1'b1, 1'b0, BIT_N);
      check_bit(rxc, 1'b0);
      $display("test address_filter done");
      // two entries queued, popped oldest first
      filt_i = 1'b0;
      rx_frame(8'h11, 8, 1'b1, 1'b1, BIT_N);
      rx_frame(8'h22, 8, 1'b1, 1'b0, BIT_N);
      wait_rxc();
      rd(v);
      check_word(v, 9'h111);
      check_bit(rxc, 1'b1);
      rd(v);
      check_word(v, 9'h022);
      check_bit(rxc, 1'b0);
      $display("test fifo_order done");
      // five-bit frames, type in first stop bit
      size_i = CHAR_SIZE_5;
      filt_i = 1'b1;
      rx_frame(8'hFF, 5, 1'b0, 1'b0, BIT_N);
      check_bit(rxc, 1'b0);
      rx_frame(8'hFF, 5, 1'b0, 1'b1, BIT_N);
      wait_rxc();
      rd(v);
      check_word(v, 9'h01F);
      $display("test short_frames done");
      // double speed: eight samples per bit
      size_i = CHAR_SIZE_9;
      filt_i = 1'b0;
      dbl_i = 1'b1;
      rx_frame(8'hA6, 8, 1'b1, 1'b1, BIT_D);
      wait_rxc();
      rd(v);
      check_word(v, 9'h1A6);
      dbl_i = 1'b0;
      $display("test double_speed done");
      // transmit with filter on; second write lands while buffer full
      filt_i = 1'b1;
      fork
         node.recv(v, 9, BIT_N);
         wr(8'h96, 8'h69, 1'b1, 2);
      join
      check_word(v, 9'h196);
      low_seen = 1'b0;
      for (int k = 0; k < 3 * BIT_N; k++) begin
         cyc(1);
         if (tx_line === 1'b0) low_seen = 1'b1;
      end
      check_bit(low_seen, 1'b0);
      check_bit(txc, 1'b1);
      check_bit(txe, 1'b1);
      @(negedge clock_i);
      txc_clr_i = 1'b1;
      @(negedge clock_i);
      txc_clr_i = 1'b0;
      cyc(2);
      check_bit(txc, 1'b0);
      // five-bit send held until enabled; upper bits dropped
      size_i = CHAR_SIZE_5;
      tx_en_i = 1'b0;
      wr(8'hEA, 8'hEA, 1'b1, 1);
      cyc(4);
      check_bit(txe, 1'b0);
      check_bit(tx_line, 1'b1);
      fork
         node.recv(v, 7, BIT_N);
         tx_en_i = 1'b1;
      join
      check_word(v, 9'h06A);
      cyc(3 * BIT_N);
      $display("test transmit done");
      give_verdict();
   end
endmodule : test_usd_core
`default_nettype wire
